// ---- design/tww_watchdog.sv ----
// Token window watchdog: period timer, answer check, error and refresh counters.
// Assumes answers arrive on the link clock and all configuration ports except wdg_otp_enable are core-clock logic.
`include "tww_cfg.svh"
`default_nettype none
module tww_watchdog #(
	parameter int HALF_TICK_CYCLES = `TWW_HALF_TICK_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic link_clk,
	input wire logic wdg_otp_enable,
	input wire logic [15:0] response_entry,
	input wire logic response_wr,
	input wire logic cfg_wr,
	input wire logic [3:0] window_period_sel,
	input wire logic window_type_select,
	input wire logic window_disable_req,
	input wire logic lowpower_wdg_disable,
	input wire logic [1:0] fail_count_limit,
	input wire logic [1:0] good_count_limit,
	input wire logic reset_reaction_en,
	input wire logic limp_reaction_en,
	input wire logic low_power_on_mode,
	input wire logic reset_out_event,
	input wire logic fail_flag_clr,
	input wire logic fault_clr,
	output logic [15:0] challenge_token,
	output logic refresh_fail_flag,
	output logic refresh_good,
	output logic refresh_bad,
	output logic [3:0] fail_count_value,
	output logic [2:0] good_count_value,
	output logic safety_init_phase,
	output logic window_open,
	output logic reset_out_pin_n,
	output logic limp_home_out,
	output logic wake_req
);

	function automatic logic [3:0] err_limit(input logic [1:0] code);
		unique case (code)
			2'h0: err_limit = 4'h8;
			2'h1: err_limit = 4'h6;
			2'h2: err_limit = 4'h4;
			2'h3: err_limit = 4'h2;
		endcase
	endfunction

	function automatic logic [2:0] rfr_limit(input logic [1:0] code);
		unique case (code)
			2'h0: rfr_limit = 3'h6;
			2'h1: rfr_limit = 3'h4;
			2'h2: rfr_limit = 3'h2;
			2'h3: rfr_limit = 3'h1;
		endcase
	endfunction

	// Period length in half-millisecond ticks
	function automatic logic [16:0] period_len(input logic [3:0] sel);
		period_len = 17'h1 << sel;
	endfunction

	// Link domain: capture answer, flag it with a toggle
	logic [15:0] link_answer;
	logic link_toggle;

	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			link_answer <= 16'h0;
			link_toggle <= 1'b0;
		end else if (response_wr) begin
			link_answer <= response_entry;
			link_toggle <= ~link_toggle;
		end
	end

	// Core domain synchronisers
	logic tgl_s1;
	logic tgl_s2;
	logic tgl_s3;
	logic otp_s1;
	logic otp_s2;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tgl_s1 <= 1'b0;
			tgl_s2 <= 1'b0;
			tgl_s3 <= 1'b0;
			otp_s1 <= 1'b0;
			otp_s2 <= 1'b0;
		end else begin
			tgl_s1 <= link_toggle;
			tgl_s2 <= tgl_s1;
			tgl_s3 <= tgl_s2;
			otp_s1 <= wdg_otp_enable;
			otp_s2 <= otp_s1;
		end
	end

	// Answer word is stable by the time its toggle has crossed
	wire answer_seen = tgl_s2 ^ tgl_s3;

	// State and configuration
	tww_pkg::tww_state_t state;
	tww_pkg::tww_state_t next_state;
	logic init_closed;
	logic [3:0] period_pend;
	logic [3:0] period_eff;
	logic type_window;
	logic win_dis_req;
	logic win_dis_eff;
	logic lp_dis;
	logic [1:0] err_lim_code;
	logic [1:0] rfr_lim_code;
	logic react_rst;
	logic react_limp;
	logic [15:0] half_div;
	logic [16:0] pcnt;
	logic [3:0] err_cnt;
	logic [2:0] rfr_cnt;
	logic fault;

	localparam tww_pkg::tww_state_t TWW_INIT_ST = tww_pkg::TWW_INIT;
	wire in_init = (state == TWW_INIT_ST);

	// Disabled by OTP, a taken window disable, low power with stop chosen, or a reset-output event
	wire wdg_off = ~otp_s2 | win_dis_eff | (low_power_on_mode & lp_dis) | reset_out_event;
	wire running = (state != tww_pkg::TWW_OFF);

	// Low power forces timeout behaviour
	wire mode_window = type_window & ~low_power_on_mode;

	wire half_tick = (half_div == HALF_TICK_CYCLES[15:0] - 16'h1);
	wire infinite = (period_eff == `TWW_PERIOD_INFINITE);
	wire [16:0] plen = period_len(period_eff);
	wire [16:0] closed_len = plen >> 1;
	wire last_tick = (pcnt == plen - 17'h1);
	wire timeout = running & half_tick & last_tick & ~infinite;
	wire is_open = ~mode_window | infinite | (pcnt >= closed_len);

	wire answer = running & answer_seen;
	wire key_ok = (link_answer == challenge_token);
	wire good = answer & key_ok & is_open;
	wire bad = (answer & ~(key_ok & is_open)) | (timeout & ~answer);
	wire refresh = good | bad;

	wire [3:0] elim = err_limit(err_lim_code);
	wire [2:0] rlim = rfr_limit(rfr_lim_code);
	wire [4:0] err_sum = {1'b0, err_cnt} + {1'b0, `TWW_ERR_STEP_UP};
	wire [3:0] err_up = (err_sum >= {1'b0, elim}) ? elim : err_sum[3:0];
	wire rfr_full = (rfr_cnt == rlim);
	wire [3:0] err_down = (rfr_full && err_cnt != 4'h0) ? err_cnt - 4'h1 : err_cnt;

	wire [3:0] next_err = bad ? err_up : (good ? err_down : err_cnt);
	wire [2:0] next_rfr = bad ? 3'h0 : ((good && !rfr_full) ? rfr_cnt + 3'h1 : rfr_cnt);
	// Only a failure reaching the limit latches, so a clear can release the pins
	wire hit_limit = running & bad & (next_err >= elim);
	wire next_fault = (fault & ~fault_clr) | hit_limit;

	always_comb begin
		next_state = state;
		unique case (state)
			tww_pkg::TWW_INIT: begin
				if (wdg_off)
					next_state = tww_pkg::TWW_OFF;
				else if (good)
					next_state = tww_pkg::TWW_RUN;
			end
			tww_pkg::TWW_RUN: begin
				if (wdg_off)
					next_state = tww_pkg::TWW_OFF;
			end
			tww_pkg::TWW_OFF: begin
				if (!wdg_off)
					next_state = init_closed ? tww_pkg::TWW_RUN : tww_pkg::TWW_INIT;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			state <= tww_pkg::TWW_INIT;
		else
			state <= next_state;
	end

	// A reset-output event reopens the initialisation phase
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			init_closed <= 1'b0;
		else if (reset_out_event)
			init_closed <= 1'b0;
		else if (in_init && good)
			init_closed <= 1'b1;
	end

	// Init-only fields; cleared only by power-on reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			err_lim_code <= `TWW_ERR_LIMIT_DEFAULT;
			rfr_lim_code <= `TWW_RFR_LIMIT_DEFAULT;
			react_rst <= 1'b1;
			react_limp <= 1'b1;
			lp_dis <= 1'b0;
		end else if (cfg_wr && in_init) begin
			err_lim_code <= fail_count_limit;
			rfr_lim_code <= good_count_limit;
			react_rst <= reset_reaction_en;
			react_limp <= limp_reaction_en;
			lp_dis <= lowpower_wdg_disable;
		end
	end

	// Window disable: latched in init, applied as init closes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			win_dis_req <= 1'b0;
			win_dis_eff <= 1'b0;
		end else begin
			if (cfg_wr && in_init)
				win_dis_req <= window_disable_req;
			if (in_init && good)
				win_dis_eff <= win_dis_req;
		end
	end

	// Runtime config; a disable restores power-on values
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			period_pend <= `TWW_PERIOD_DEFAULT;
			period_eff <= `TWW_PERIOD_DEFAULT;
			type_window <= 1'b0;
		end else if (!running) begin
			period_pend <= `TWW_PERIOD_DEFAULT;
			period_eff <= `TWW_PERIOD_DEFAULT;
			type_window <= 1'b0;
		end else begin
			if (cfg_wr) begin
				period_pend <= window_period_sel;
				type_window <= window_type_select;
			end
			if (refresh)
				period_eff <= cfg_wr ? window_period_sel : period_pend;
		end
	end

	// Prescaler runs freely; period counter restarts on every refresh
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			half_div <= 16'h0;
		else if (half_tick)
			half_div <= 16'h0;
		else
			half_div <= half_div + 16'h1;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			pcnt <= 17'h0;
		else if (!running || refresh)
			pcnt <= 17'h0;
		else if (half_tick && !infinite)
			pcnt <= pcnt + 17'h1;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			challenge_token <= `TWW_TOKEN_FIRST;
		else if (!running)
			challenge_token <= `TWW_TOKEN_FIRST;
		else if (good)
			challenge_token <= (challenge_token == `TWW_TOKEN_FIRST) ? `TWW_TOKEN_SECOND : `TWW_TOKEN_FIRST;
	end

	// Error and refresh counters and the fault survive a disable; only the period, the type and the token are restored
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			err_cnt <= 4'h0;
			rfr_cnt <= 3'h0;
			fault <= 1'b0;
		end else begin
			err_cnt <= next_err;
			rfr_cnt <= next_rfr;
			fault <= next_fault;
		end
	end

	// Registered outputs
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			refresh_fail_flag <= 1'b0;
			refresh_good <= 1'b0;
			refresh_bad <= 1'b0;
			fail_count_value <= 4'h0;
			good_count_value <= 3'h0;
			safety_init_phase <= 1'b1;
			window_open <= 1'b1;
			reset_out_pin_n <= 1'b1;
			limp_home_out <= 1'b0;
			wake_req <= 1'b0;
		end else begin
			// Set wins over a clear in the same cycle
			refresh_fail_flag <= bad | (refresh_fail_flag & ~fail_flag_clr);
			refresh_good <= good;
			refresh_bad <= bad;
			fail_count_value <= next_err;
			good_count_value <= next_rfr;
			safety_init_phase <= (next_state == tww_pkg::TWW_INIT);
			window_open <= is_open;
			reset_out_pin_n <= ~(next_fault & react_rst);
			limp_home_out <= next_fault & react_limp;
			wake_req <= hit_limit & ~fault & low_power_on_mode;
		end
	end

endmodule // tww_watchdog
`default_nettype wire

// ---- inc/tww_cfg.svh ----
// Constants of the token window watchdog: reset values, limits, timing.
// Assumes a 125 MHz core clock; the overview below lists the behaviour kept.
//
// Overview of operation
// - Window mode: first half of each period closed, second half open.
// - Good refresh only for a correct answer in the open window.
// - Any good or bad refresh restarts the period immediately.
// - First good refresh ends the initialisation phase.
// - A one-time-programmable bit enables or disables the whole watchdog.
// - Period code 0 is infinite; codes 1..15 give 1 ms doubling; default 256 ms.
// - A newly written period applies only after the next refresh.
// - Window disable accepted only in init; effective when init closes.
// - Token starts 0x5AB2 and swaps with 0xD564 after each good refresh.
// - On disable, token, period and type return to power-on values.
// - Low-power-on mode keeps or stops the watchdog; running means timeout mode.
// - Type select 0 is timeout mode (default), 1 is window mode.
// - Timeout mode: wrong answer or expiry counts an error and sets the flag.
// - Window mode: wrong, early or missing answer counts an error, sets flag.
// - Failures add 2 to the error counter, proper refreshes at the refresh limit subtract 1.
// - Error limit code 00/01/10/11 gives 8/6/4/2; default 6; power-on cleared.
// - Error counter value readable as 4 bits.
// - Good refreshes count up; at the limit a further good one decrements errors.
// - Any bad refresh clears the refresh counter.
// - Refresh limit code 00/01/10/11 gives 6/4/2/1; count readable as 3 bits.
// - At error limit, reset and limp outputs follow their reaction bits; wake in low power.
// - Closed part is half the period, within 47.5 to 52.5 percent.
`ifndef TWW_CFG_SVH
`define TWW_CFG_SVH
`define TWW_TOKEN_FIRST 16'h5ab2
`define TWW_TOKEN_SECOND 16'hd564
`define TWW_PERIOD_DEFAULT 4'h9
`define TWW_PERIOD_INFINITE 4'h0
`define TWW_ERR_LIMIT_DEFAULT 2'h1
`define TWW_RFR_LIMIT_DEFAULT 2'h0
`define TWW_ERR_STEP_UP 4'h2
`define TWW_CLK_HZ 125000000
`define TWW_HALF_TICK_US 500
`define TWW_HALF_TICK_CYCLES ((`TWW_CLK_HZ / 1000000) * `TWW_HALF_TICK_US)
`endif

// ---- inc/tww_pkg.sv ----
// Types shared by the token window watchdog.
// Assumes the constants header is included by each user.
`default_nettype none
package tww_pkg;
	typedef enum logic [1:0] {
		TWW_INIT,
		TWW_RUN,
		TWW_OFF
	} tww_state_t;
endpackage
`default_nettype wire

// ---- tb/test_token_window_watchdog.sv ----
// Self-checking bench for the token window watchdog.
// Assumes the controller model and a short half tick.
`default_nettype none
module test_token_window_watchdog;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rst, link_clk, wdg_otp_enable, response_wr, cfg_wr, window_type_select, window_disable_req;
	logic lowpower_wdg_disable, reset_reaction_en, limp_reaction_en, low_power_on_mode, reset_out_event;
	logic fail_flag_clr, fault_clr, refresh_fail_flag, refresh_good, refresh_bad, safety_init_phase;
	logic window_open, reset_out_pin_n, limp_home_out, wake_req, go;
	logic [15:0] response_entry, challenge_token, word, exp_tok, bad_word;
	logic [3:0] window_period_sel, fail_count_value, exp_err;
	logic [2:0] good_count_value, exp_gc;
	logic [1:0] fail_count_limit, good_count_limit;
	int mismatches, n_tests, seed, i, n;
	tww_watchdog #(.HALF_TICK_CYCLES(4)) dut (.*);
	tww_mcu mcu (.go(go), .word(word), .link_clk(link_clk), .response_wr(response_wr), .response_entry(response_entry));
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (exp !== got) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	function automatic logic [15:0] swap(input logic [15:0] t);
		return (t == 16'h5ab2) ? 16'hd564 : 16'h5ab2;
	endfunction
	task automatic verdict(input logic good, output int cyc);
		cyc = 0;
		while (refresh_good !== 1'b1 && refresh_bad !== 1'b1 && cyc < 600) begin
			@(negedge clk);
			cyc++;
		end
		chk("verdict", {14'h0, good, !good}, {14'h0, refresh_good, refresh_bad});
		if (good) begin
			exp_tok = swap(exp_tok);
			if (exp_gc == 3'h2)
				exp_err = (exp_err == 4'h0) ? 4'h0 : exp_err - 4'h1;
			else
				exp_gc++;
		end else begin
			exp_gc = 3'h0;
			exp_err = (exp_err > 4'h6) ? 4'h8 : exp_err + 4'h2;
			chk("flag", 16'h1, {15'h0, refresh_fail_flag});
		end
		chk("token", exp_tok, challenge_token);
		chk("errors", {12'h0, exp_err}, {12'h0, fail_count_value});
		chk("refreshes", {13'h0, exp_gc}, {13'h0, good_count_value});
		@(negedge clk);
	endtask
	task automatic answer(input logic [15:0] w, input logic good);
		word = w;
		go = 1'b1;
		@(negedge clk);
		go = 1'b0;
		verdict(good, n);
		repeat (60) @(negedge clk);
	endtask
	task automatic pulse_cfg;
		cfg_wr = 1'b1;
		@(negedge clk);
		cfg_wr = 1'b0;
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		#200000;
		mismatches++;
		end_of_test;
	end
	initial begin
		seed = 4048;
		rst = 1'b1;
		{cfg_wr, window_type_select, window_disable_req, lowpower_wdg_disable, low_power_on_mode} = 5'h00;
		{reset_out_event, fail_flag_clr, fault_clr, go} = 4'h0;
		{wdg_otp_enable, reset_reaction_en, limp_reaction_en} = 3'h7;
		{window_period_sel, fail_count_limit, good_count_limit} = 8'h62;
		word = 16'h0000;
		{exp_tok, exp_err, exp_gc} = {16'h5ab2, 4'h0, 3'h0};
		repeat (5) @(negedge clk);
		rst = 1'b0;
		chk("token", 16'h5ab2, challenge_token);
		chk("pins", 16'h2, {14'h0, reset_out_pin_n, limp_home_out});
		repeat (6) @(negedge clk);
		chk("init", 16'h1, {15'h0, safety_init_phase});
		pulse_cfg;
		bad_word = $random(seed);
		answer((bad_word == exp_tok) ? ~bad_word : bad_word, 1'b0);
		chk("init", 16'h1, {15'h0, safety_init_phase});
		for (i = 0; i < 4; i++)
			answer(exp_tok, 1'b1);
		chk("init", 16'h0, {15'h0, safety_init_phase});
		window_type_select = 1'b1;
		pulse_cfg;
		answer(exp_tok, 1'b0);
		for (i = 0; i < 300 && window_open !== 1'b1; i++)
			@(negedge clk);
		chk("closed span", 16'h1, {15'h0, i + 61 >= 122 && i + 61 <= 134});
		answer(exp_tok, 1'b1);
		window_type_select = 1'b0;
		pulse_cfg;
		for (i = 0; i < 4; i++)
			verdict(1'b0, n);
		chk("period", 16'h1, {15'h0, n >= 250 && n <= 258});
		chk("pins", 16'h1, {14'h0, reset_out_pin_n, limp_home_out});
		fault_clr = 1'b1;
		@(negedge clk);
		fault_clr = 1'b0;
		chk("pins", 16'h2, {14'h0, reset_out_pin_n, limp_home_out});
		reset_out_event = 1'b1;
		repeat (4) @(negedge clk);
		chk("token", 16'h5ab2, challenge_token);
		reset_out_event = 1'b0;
		exp_tok = 16'h5ab2;
		repeat (6) @(negedge clk);
		chk("init", 16'h1, {15'h0, safety_init_phase});
		wdg_otp_enable = 1'b0;
		repeat (4) @(negedge clk);
		word = exp_tok;
		go = 1'b1;
		@(negedge clk);
		go = 1'b0;
		for (n = 0; n < 600 && refresh_good !== 1'b1; n++)
			@(negedge clk);
		chk("ignored", 16'h258, n[15:0]);
		end_of_test;
	end
endmodule // test_token_window_watchdog
`default_nettype wire

// ---- tb/tww_mcu.sv ----
// Controller model: one answer over the link per go pulse.
// Link clock runs only around a write, plus one edge for reset.
`default_nettype none
module tww_mcu (
	input wire logic go,
	input wire logic [15:0] word,
	output logic link_clk,
	output logic response_wr,
	output logic [15:0] response_entry
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		link_clk = 1'b0;
		response_wr = 1'b0;
		response_entry = 16'h0000;
		#7 link_clk = 1'b1;
		#9 link_clk = 1'b0;
	end
	// Released data inverted so a stale word never looks valid
	always @(posedge go) begin
		#37 response_entry = word;
		response_wr = 1'b1;
		#80 link_clk = 1'b1;
		#80 link_clk = 1'b0;
		response_wr = 1'b0;
		response_entry = ~word;
		repeat (2) begin
			#80 link_clk = 1'b1;
			#80 link_clk = 1'b0;
		end
	end
endmodule // tww_mcu
`default_nettype wire

// ---- tb/tww_monitor.sv ----
// Checker on the watchdog outputs.
// Assumes it is bound to tww_watchdog and sees only its ports.
`default_nettype none
module tww_monitor #(
	parameter int HALF_TICK_CYCLES = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic fault_clr,
	input wire logic fail_flag_clr,
	input wire logic reset_out_event,
	input wire logic [15:0] challenge_token,
	input wire logic refresh_fail_flag,
	input wire logic refresh_good,
	input wire logic refresh_bad,
	input wire logic [3:0] fail_count_value,
	input wire logic [2:0] good_count_value,
	input wire logic reset_out_pin_n,
	input wire logic limp_home_out,
	input wire logic wake_req
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_one_verdict: assert property (!(refresh_good && refresh_bad)) else $error("two verdicts");
	a_token_swaps: assert property (refresh_good |-> challenge_token != $past(challenge_token)
		&& challenge_token inside {16'h5ab2, 16'hd564}) else $error("token not swapped");
	a_bad_clears: assert property (refresh_bad |-> good_count_value == 3'h0 && refresh_fail_flag)
		else $error("bad refresh effects");
	a_fail_adds_two: assert property (refresh_bad |-> fail_count_value == $past(fail_count_value) + 4'h2
		|| (fail_count_value >= $past(fail_count_value) && fail_count_value inside {4'h2, 4'h4, 4'h6, 4'h8}))
		else $error("error step wrong");
	a_good_counts: assert property (refresh_good |-> good_count_value == $past(good_count_value) + 3'h1
		|| (good_count_value == $past(good_count_value) && $past(fail_count_value) - fail_count_value <= 4'h1))
		else $error("refresh count wrong");
	a_fault_holds: assert property (!reset_out_pin_n && !fault_clr && !reset_out_event |=> !reset_out_pin_n)
		else $error("fault released");
	a_flag_sticky: assert property (refresh_fail_flag && !fail_flag_clr && !reset_out_event |=> refresh_fail_flag)
		else $error("flag dropped");
	a_fault_cause: assert property ($fell(reset_out_pin_n) || $rose(limp_home_out) || wake_req |-> refresh_bad)
		else $error("fault without failure");
	a_limit_range: assert property (fail_count_value <= 4'h8) else $error("error count over range");
endmodule // tww_monitor
bind tww_watchdog tww_monitor #(.HALF_TICK_CYCLES(HALF_TICK_CYCLES)) u_mon (.*);
`default_nettype wire
